// ===== rtl/mfal_fault_alert.v
// Fault status, masking and open-drain alert logic of a voltage and temperature monitor
`timescale 1ns/100ps
`include "mfal_defs.vh"
module mfal_fault_alert #(
  parameter DATA_W = 8,
  parameter NUM_VOLT = `MFAL_NUM_VOLT
) (
  input wire sys_clk,
  input wire rst,
  // Conversion results from the measurement sequencer
  input wire adc_valid,
  input wire [2:0] adc_chan,
  input wire [DATA_W-1:0] adc_code,
  // Configuration bits held by the configuration register
  input wire cfg_run,
  input wire cfg_alert_en,
  input wire cfg_alert_clr,
  // Register access from the serial management front end
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_q,
  // Monitoring loop permission
  output reg conv_run_q,
  // Open-drain alert pin
  output reg alert_out_q,
  output reg alert_oe_q
);

  localparam NSRC = `MFAL_NUM_SRC;

  // One-time mode states
  localparam OT_ARMED = 2'b01;
  localparam OT_TRIPPED = 2'b10;

  reg [DATA_W-1:0] hot_limit_q;
  reg [DATA_W-1:0] hysteresis_limit_q;
  reg [NSRC-1:0] fault_status_q;
  reg [NSRC-1:0] fault_mask_q;
  reg [1:0] temp_irq_mode_q;
  // Limit storage: even index high limit, odd index low limit
  reg [DATA_W-1:0] vlim_q [0:2*NUM_VOLT-1];
  // Last result of each channel
  reg [DATA_W-1:0] result_q [0:NSRC-1];
  // Temperature history per mode
  reg hot_latch_q;
  reg hot_cond_q;
  reg [1:0] ot_state_q;
  reg alert_latch_q;

  reg [NSRC-1:0] fault_status_d;
  reg [NSRC-1:0] clear_bits;
  reg [1:0] ot_state_d;
  reg hot_latch_d;
  reg temp_event;
  reg alert_latch_d;
  reg alert_oe_d;
  reg [7:0] rdata_d;
  reg hot_cond_d;
  reg ot_event;

  wire [NUM_VOLT-1:0] volt_oor;
  wire [NSRC-1:0] raw_event;
  wire [NSRC-1:0] src_event;
  wire is_temp;
  wire temp_above_hot;
  wire temp_below_hyst;
  wire mode_cmp;
  wire mode_one;
  wire status_read;
  wire [7:0] vlim_idx;
  wire [7:0] res_idx;
  wire cmp_alert;
  wire hit_hot;
  wire hit_hyst;
  wire hit_status;
  wire hit_mask;
  wire hit_mode;
  wire hit_vlim;
  wire hit_result;
  wire wr_hot;
  wire wr_hyst;
  wire wr_mask;
  wire wr_mode;
  wire wr_vlim;

  assign is_temp = adc_valid && (adc_chan == `MFAL_CHAN_TEMP);
  // Temperature codes are two's complement degrees
  assign temp_above_hot = ($signed(adc_code) > $signed(hot_limit_q));
  assign temp_below_hyst = ($signed(adc_code) < $signed(hysteresis_limit_q));
  assign mode_cmp = (temp_irq_mode_q == `MFAL_MODE_COMPARATOR);
  assign mode_one = (temp_irq_mode_q == `MFAL_MODE_ONE_TIME);
  assign status_read = reg_rd && (reg_addr == `MFAL_ADDR_FAULT_STATUS);
  assign vlim_idx = reg_addr - `MFAL_ADDR_VLIM_FIRST;
  assign res_idx = reg_addr - `MFAL_ADDR_RESULT_BASE;

  // Address decodes of the read mux; all but status and result also feed the write path
  assign hit_hot = (reg_addr == `MFAL_ADDR_HOT_LIMIT);
  assign hit_hyst = (reg_addr == `MFAL_ADDR_HYST_LIMIT);
  assign hit_status = (reg_addr == `MFAL_ADDR_FAULT_STATUS);
  assign hit_mask = (reg_addr == `MFAL_ADDR_FAULT_MASK);
  assign hit_mode = (reg_addr == `MFAL_ADDR_TEMP_IRQ_MODE);
  assign hit_vlim = (reg_addr >= `MFAL_ADDR_VLIM_FIRST) && (reg_addr <= `MFAL_ADDR_VLIM_LAST);
  assign hit_result = (reg_addr >= `MFAL_ADDR_RESULT_BASE) && (res_idx < NSRC);

  // Write strobes
  assign wr_hot = reg_wr && hit_hot;
  assign wr_hyst = reg_wr && hit_hyst;
  assign wr_mask = reg_wr && hit_mask;
  assign wr_mode = reg_wr && hit_mode;
  assign wr_vlim = reg_wr && hit_vlim;

  // Per-rail window compare; limits at even index high, odd index low
  genvar gi;
  generate
    for (gi = 0; gi < NUM_VOLT; gi = gi + 1) begin : g_volt
      mfal_window_cmp #(
        .WIDTH(DATA_W)
      ) u_cmp (
        .code(adc_code),
        .voltage_low_limit(vlim_q[2*gi+1]),
        .voltage_high_limit(vlim_q[2*gi]),
        .out_of_range(volt_oor[gi])
      );
      // Each out-of-range conversion is a fresh event
      assign raw_event[gi] = adc_valid && (adc_chan == gi) && volt_oor[gi];
    end
  endgenerate

  assign raw_event[`MFAL_BIT_TEMP] = temp_event;
  assign src_event = raw_event & ~fault_mask_q;
  // Comparator alert follows the live condition, not the status read
  assign cmp_alert = mode_cmp && hot_cond_d && !fault_mask_q[`MFAL_BIT_TEMP];

  // Next comparator condition, so the alert follows in the conversion's own cycle
  always @* begin
    hot_cond_d = 1'b0;
    if (mode_cmp) begin
      hot_cond_d = hot_cond_q;
      if (is_temp) begin
        hot_cond_d = temp_above_hot;
      end
    end
  end

  // One-time mode: one event on going hot, one on falling below hysteresis
  always @* begin
    ot_state_d = ot_state_q;
    ot_event = 1'b0;
    if (is_temp && mode_one) begin
      case (ot_state_q)
        OT_ARMED: begin
          if (temp_above_hot) begin
            ot_event = 1'b1;
            ot_state_d = OT_TRIPPED;
          end
        end
        OT_TRIPPED: begin
          if (temp_below_hyst) begin
            ot_event = 1'b1;
            ot_state_d = OT_ARMED;
          end
        end
        default: begin
          ot_state_d = OT_ARMED;
        end
      endcase
    end
  end

  // Temperature event generation per mode
  always @* begin
    hot_latch_d = hot_latch_q;
    temp_event = 1'b0;
    if (is_temp) begin
      if (mode_cmp) begin
        temp_event = temp_above_hot;
      end else if (mode_one) begin
        temp_event = ot_event;
      end else begin
        // Hysteresis latch keeps alerts coming on every measurement until one falls below the hysteresis limit
        if (temp_above_hot) begin
          hot_latch_d = 1'b1;
        end else if (temp_below_hyst) begin
          hot_latch_d = 1'b0;
        end
        temp_event = temp_above_hot || (hot_latch_q && !temp_below_hyst);
      end
    end
  end

  // Status clearing and update; new events win over the clear
  always @* begin
    clear_bits = {NSRC{1'b0}};
    if (status_read) begin
      clear_bits = {NSRC{1'b1}};
      if (mode_cmp && hot_cond_q) begin
        clear_bits[`MFAL_BIT_TEMP] = 1'b0;
      end
    end
    fault_status_d = (fault_status_q & ~clear_bits) | src_event;
    // Bits of masked sources never show
    fault_status_d = fault_status_d & ~fault_mask_q;
  end

  // Latched part of the alert; comparator temperature goes through cmp_alert
  always @* begin
    alert_latch_d = alert_latch_q;
    if (status_read || cfg_alert_clr) begin
      alert_latch_d = 1'b0;
    end
    if (|src_event[NUM_VOLT-1:0]) begin
      alert_latch_d = 1'b1;
    end
    if (src_event[`MFAL_BIT_TEMP] && !mode_cmp) begin
      alert_latch_d = 1'b1;
    end
    alert_oe_d = cfg_alert_en && !cfg_alert_clr && (alert_latch_d || cmp_alert);
  end

  // Register read mux, reserved bits read zero
  always @* begin
    rdata_d = 8'h00;
    if (hit_hot) begin
      rdata_d = hot_limit_q;
    end else if (hit_hyst) begin
      rdata_d = hysteresis_limit_q;
    end else if (hit_status) begin
      rdata_d = {3'h0, fault_status_q};
    end else if (hit_mask) begin
      rdata_d = {3'h0, fault_mask_q};
    end else if (hit_mode) begin
      rdata_d = {6'h00, temp_irq_mode_q};
    end else if (hit_vlim) begin
      rdata_d = vlim_q[vlim_idx[2:0]];
    end else if (hit_result) begin
      // Latest results stay readable while the alert is active
      rdata_d = result_q[res_idx[2:0]];
    end
  end

  // Host-programmed limits, mask and mode
  integer i;
  always @(posedge sys_clk) begin
    if (rst) begin
      hot_limit_q <= `MFAL_RST_HOT_LIMIT;
      hysteresis_limit_q <= `MFAL_RST_HYST_LIMIT;
      for (i = 0; i < NUM_VOLT; i = i + 1) begin
        vlim_q[2*i] <= `MFAL_RST_VOLT_HIGH;
        vlim_q[2*i+1] <= `MFAL_RST_VOLT_LOW;
      end
      fault_mask_q <= `MFAL_RST_FAULT_MASK;
      temp_irq_mode_q <= `MFAL_RST_TEMP_IRQ_MODE;
    end else begin
      if (wr_hot) begin
        hot_limit_q <= reg_wdata;
      end
      if (wr_hyst) begin
        hysteresis_limit_q <= reg_wdata;
      end
      if (wr_mask) begin
        fault_mask_q <= reg_wdata[NSRC-1:0];
      end
      if (wr_mode) begin
        temp_irq_mode_q <= reg_wdata[1:0];
      end
      if (wr_vlim) begin
        vlim_q[vlim_idx[2:0]] <= reg_wdata;
      end
    end
  end

  // Latest result per channel, captured whatever the alert state
  integer j;
  always @(posedge sys_clk) begin
    if (rst) begin
      for (j = 0; j < NSRC; j = j + 1) begin
        result_q[j] <= 8'h00;
      end
    end else if (adc_valid && adc_chan < NSRC) begin
      result_q[adc_chan] <= adc_code;
    end
  end

  // Fault status, temperature mode state and latched alert
  always @(posedge sys_clk) begin
    if (rst) begin
      fault_status_q <= `MFAL_RST_FAULT_STATUS;
      hot_latch_q <= 1'b0;
      hot_cond_q <= 1'b0;
      ot_state_q <= OT_ARMED;
      alert_latch_q <= 1'b0;
    end else begin
      fault_status_q <= fault_status_d;
      hot_latch_q <= hot_latch_d;
      hot_cond_q <= hot_cond_d;
      ot_state_q <= ot_state_d;
      alert_latch_q <= alert_latch_d;
    end
  end

  // Output flops; pin data is a constant low, only the enable moves
  always @(posedge sys_clk) begin
    if (rst) begin
      alert_oe_q <= 1'b0;
      alert_out_q <= 1'b0;
      conv_run_q <= 1'b0;
      reg_rdata_q <= 8'h00;
    end else begin
      if (reg_rd) begin
        reg_rdata_q <= rdata_d;
      end
      alert_oe_q <= alert_oe_d;
      alert_out_q <= 1'b0;
      // Alert never stops conversions; only cfg_run low or the clear bit holds them
      conv_run_q <= cfg_run && !cfg_alert_clr;
    end
  end

endmodule // mfal_fault_alert

// ===== rtl/mfal_defs.vh
// Register map, field positions, reset values and mode codes of the fault alert logic
`ifndef MFAL_DEFS_VH
`define MFAL_DEFS_VH

`define MFAL_ADDR_VLIM_FIRST 8'h2b
`define MFAL_ADDR_VLIM_LAST 8'h32
`define MFAL_ADDR_HOT_LIMIT 8'h39
`define MFAL_ADDR_HYST_LIMIT 8'h3a
`define MFAL_ADDR_FAULT_STATUS 8'h41
`define MFAL_ADDR_FAULT_MASK 8'h43
`define MFAL_ADDR_TEMP_IRQ_MODE 8'h4b
`define MFAL_ADDR_RESULT_BASE 8'h20

`define MFAL_RST_HOT_LIMIT 8'h50
`define MFAL_RST_HYST_LIMIT 8'h41
`define MFAL_RST_FAULT_STATUS 5'h00
`define MFAL_RST_FAULT_MASK 5'h00
`define MFAL_RST_TEMP_IRQ_MODE 2'h0
`define MFAL_RST_VOLT_HIGH 8'hd3
`define MFAL_RST_VOLT_LOW 8'hac

`define MFAL_BIT_MID_RAIL 0
`define MFAL_BIT_LOW_RAIL 1
`define MFAL_BIT_HIGH_RAIL 2
`define MFAL_BIT_SUPPLY 3
`define MFAL_BIT_TEMP 4
`define MFAL_NUM_VOLT 4
`define MFAL_NUM_SRC 5

`define MFAL_MODE_DEFAULT 2'h0
`define MFAL_MODE_ONE_TIME 2'h1
`define MFAL_MODE_COMPARATOR 2'h2
`define MFAL_MODE_DEFAULT_ALT 2'h3

`define MFAL_CHAN_TEMP 3'h4

`endif

// ===== rtl/mfal_window_cmp.v
// Window comparator of one voltage result against its low and high limits
`timescale 1ns/100ps
module mfal_window_cmp #(
  parameter WIDTH = 8
) (
  input wire [WIDTH-1:0] code,
  input wire [WIDTH-1:0] voltage_low_limit,
  input wire [WIDTH-1:0] voltage_high_limit,
  output wire out_of_range
);
  assign out_of_range = (code < voltage_low_limit) | (code > voltage_high_limit);
endmodule // mfal_window_cmp

// ===== test/mfal_checker.sv
// Port-level assertions of the fault alert logic
`timescale 1ns/100ps
module mfal_checker (
  input wire sys_clk,
  input wire rst,
  input wire adc_valid,
  input wire [2:0] adc_chan,
  input wire [7:0] adc_code,
  input wire cfg_run,
  input wire cfg_alert_en,
  input wire cfg_alert_clr,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_q,
  input wire conv_run_q,
  input wire alert_out_q,
  input wire alert_oe_q
);
  reg [4:0] mask_q;
  reg [1:0] mode_q;
  reg [7:0] hot_q;
  wire live_en = cfg_alert_en && !cfg_alert_clr;
  // Shadow of mask, mode and hot limit
  always @(posedge sys_clk) begin
    if (rst) begin
      mask_q <= 5'h00;
      mode_q <= 2'h0;
      hot_q <= 8'h50;
    end else if (reg_wr && reg_addr == 8'h43) begin
      mask_q <= reg_wdata[4:0];
    end else if (reg_wr && reg_addr == 8'h4b) begin
      mode_q <= reg_wdata[1:0];
    end else if (reg_wr && reg_addr == 8'h39) begin
      hot_q <= reg_wdata;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  drain_low_a: assert property (alert_out_q == 1'b0) else $error("alert data high");
  en_off_a: assert property (!cfg_alert_en |=> !alert_oe_q) else $error("alert while disabled");
  clr_rel_a: assert property (cfg_alert_clr |=> !alert_oe_q) else $error("alert while clear");
  run_hold_a: assert property (1'b1 |=> conv_run_q == $past(cfg_run && !cfg_alert_clr)) else $error("run wrong");
  volt_hit_a: assert property ((adc_valid && adc_chan < 3'h4 && adc_code == 8'hff
    && !mask_q[adc_chan[1:0]] && live_en) ##1 live_en |-> alert_oe_q) else $error("voltage fault silent");
  mask_off_a: assert property ((adc_valid && adc_chan < 3'h4 && mask_q[adc_chan[1:0]]
    && !alert_oe_q && live_en && $past(live_en)) ##1 live_en |-> !alert_oe_q) else $error("masked source alerted");
  rd_clr_a: assert property (reg_rd && reg_addr == 8'h41 && mode_q != 2'h2 && !adc_valid
    |=> !alert_oe_q) else $error("read kept alert");
  rsv_zero_a: assert property (reg_rd && reg_addr == 8'h41
    |=> reg_rdata_q[7:5] == 3'h0) else $error("reserved bits set");
  cmp_hot_a: assert property ((adc_valid && adc_chan == 3'h4 && mode_q == 2'h2
    && $signed(adc_code) > $signed(hot_q) && !mask_q[4] && live_en) ##1 live_en |-> alert_oe_q)
    else $error("comparator alert late");
endmodule // mfal_checker
bind mfal_fault_alert mfal_checker i_mfal_checker (.sys_clk, .rst, .adc_valid, .adc_chan, .adc_code, .cfg_run,
  .cfg_alert_en, .cfg_alert_clr, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_q, .conv_run_q,
  .alert_out_q, .alert_oe_q);

// ===== test/mfal_host.sv
// Management host model with pulled-up alert line
`timescale 1ns/100ps
module mfal_host (
  input wire sys_clk,
  input wire alert_oe_q,
  output reg [7:0] reg_addr,
  output reg reg_wr,
  output reg reg_rd,
  output reg [7:0] reg_wdata,
  output wire alert_n
);
  assign alert_n = alert_oe_q ? 1'b0 : 1'b1;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // One access, then an idle cycle
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    begin
      reg_addr = a;
      reg_wdata = d;
      reg_wr = w;
      reg_rd = !w;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
      @(posedge sys_clk);
      #1;
    end
  endtask
endmodule // mfal_host

// ===== test/tb_top.sv
// Self-checking bench of the fault alert logic
`timescale 1ns/100ps
module tb_top;
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg adc_valid = 1'b0;
  reg [2:0] adc_chan = 3'h0;
  reg [7:0] adc_code = 8'h00;
  reg cfg_run = 1'b1;
  reg cfg_alert_en = 1'b1;
  reg cfg_alert_clr = 1'b0;
  wire [7:0] reg_addr, reg_wdata, reg_rdata_q;
  wire reg_wr, reg_rd, conv_run_q, alert_out_q, alert_oe_q, alert_n;
  integer err_total = 0;
  integer n_tests = 0;
  integer cyc = 0;
  integer i;
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      wrap_up;
    end
  end
  mfal_fault_alert i_mfal_fault_alert (.sys_clk, .rst, .adc_valid, .adc_chan, .adc_code, .cfg_run, .cfg_alert_en,
    .cfg_alert_clr, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_q, .conv_run_q, .alert_out_q, .alert_oe_q);
  mfal_host i_mfal_host (.sys_clk, .alert_oe_q, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .alert_n);
  task wrap_up;
    begin
      if (err_total == 0 && n_tests > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  task chk(input [39:0] w, input [7:0] a, input [7:0] e, input [7:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("[FAIL] %0s %h expected %h seen %h", w, a, e, g);
      end
    end
  endtask
  task rc(input [7:0] a, input [7:0] e);
    begin
      i_mfal_host.acc(1'b0, a, 8'h00);
      chk("read", a, e, reg_rdata_q);
    end
  endtask
  task pin(input e);
    begin
      chk("alert", 8'h00, {7'h00, e}, {7'h00, alert_n});
    end
  endtask
  task adc(input [2:0] c, input [7:0] d);
    begin
      adc_chan = c;
      adc_code = d;
      adc_valid = 1'b1;
      @(posedge sys_clk);
      #1;
      adc_valid = 1'b0;
      adc_chan = 3'h7;
      @(posedge sys_clk);
      #1;
    end
  endtask
  task step;
    begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    step;
    rc(8'h39, 8'h50);
    rc(8'h3a, 8'h41);
    for (i = 0; i < 4; i = i + 1) begin
      rc(8'h2b + {i[6:0], 1'b0}, 8'hd3);
      rc(8'h2c + {i[6:0], 1'b0}, 8'hac);
    end
    chk("run", 8'h00, 8'h01, {7'h00, conv_run_q});
    for (i = 0; i < 4; i = i + 1) begin
      adc(i[2:0], i[0] ? 8'h00 : 8'hff);
      pin(1'b0);
      rc(8'h20 + i[7:0], i[0] ? 8'h00 : 8'hff);
      rc(8'h41, 8'h01 << i);
      pin(1'b1);
    end
    i_mfal_host.acc(1'b1, 8'h43, 8'h04);
    adc(3'h2, 8'hff);
    pin(1'b1);
    rc(8'h41, 8'h00);
    i_mfal_host.acc(1'b1, 8'h43, 8'h00);
    cfg_alert_en = 1'b0;
    adc(3'h0, 8'hff);
    pin(1'b1);
    cfg_alert_en = 1'b1;
    step;
    cfg_alert_clr = 1'b1;
    step;
    step;
    pin(1'b1);
    chk("run", 8'h00, 8'h00, {7'h00, conv_run_q});
    cfg_alert_clr = 1'b0;
    rc(8'h41, 8'h01);
    for (i = 0; i < 4; i = i + 3) begin
      i_mfal_host.acc(1'b1, 8'h4b, i[7:0]);
      adc(3'h4, 8'h55);
      rc(8'h41, 8'h10);
      pin(1'b1);
      adc(3'h4, 8'h46);
      pin(1'b0);
      adc(3'h4, 8'h3c);
      rc(8'h41, 8'h10);
      rc(8'h41, 8'h00);
    end
    i_mfal_host.acc(1'b1, 8'h4b, 8'h01);
    adc(3'h4, 8'h55);
    rc(8'h41, 8'h10);
    adc(3'h4, 8'h55);
    pin(1'b1);
    adc(3'h4, 8'h3c);
    pin(1'b0);
    rc(8'h41, 8'h10);
    i_mfal_host.acc(1'b1, 8'h4b, 8'h02);
    rc(8'h4b, 8'h02);
    adc(3'h4, 8'h55);
    adc(3'h0, 8'hff);
    rc(8'h41, 8'h11);
    pin(1'b0);
    rc(8'h41, 8'h10);
    adc(3'h4, 8'h4b);
    pin(1'b1);
    rc(8'h41, 8'h10);
    rc(8'h41, 8'h00);
    fork
      i_mfal_host.acc(1'b0, 8'h41, 8'h00);
      adc(3'h3, 8'hff);
    join
    rc(8'h41, 8'h08);
    wrap_up;
  end
endmodule // tb_top
